// *** fp_pkg.sv ***
// constants and carrier types for the lookup action frame pointer block
// assumes a single core clock domain and an APB master for the registers
// Operation
// - forcing on: pipeline point from short 3-bit or full 5-bit field
// - 4-bit next key select: 0 default, 1..14 force key, 15 stop lookups
// - key 8 puts destination MAC and IPv4 in source key fields
// - key 5 picks triple tag or triple tag index key by per-lookup bit; here cfg bit 0 picks it for every lookup
// - pointer advances by 2-bit word offset times four bytes
// - pointer advances by 5-bit halfword offset times two bytes
// - skipped reserved labels are passed already, not counted in offsets
// - layer skip applies first, explicit offset added afterwards
// - layer skip 0 none, 1 passes MACs and 0..3 tags, 3 reserved
// - skip 2 also passes IP header with options, control word with IP too
// - new layer loaded only if pointer moved, or raw data with key select
// - layer codes: ethernet, control word, label, raw data
// - normalize asks rewriter to strip all bytes before the pointer
// - pointer update completes before the strip request uses it
// - strip request never exceeds 42 bytes
// - 2-bit force code none, extract, inject, loopback; overrides point
package fp_pkg;
    localparam int PTR_W = 8;
    localparam logic [7:0] MAX_STRIP = 8'd42;
    localparam logic [7:0] MAC_BYTES = 8'd12;
    localparam logic [7:0] TAG_BYTES = 8'd4;
    localparam logic [7:0] TYPE_BYTES = 8'd2;
    localparam logic [7:0] IP6_BYTES = 8'd40;
    localparam logic [3:0] KEY_DEFAULT = 4'h0;
    localparam logic [3:0] KEY_TRIPLE = 4'h5;
    localparam logic [3:0] KEY_NORMAL_DST = 4'h8;
    localparam logic [3:0] KEY_DONE = 4'hf;
    localparam logic [3:0] KEY_TRIPLE_IDX_OUT = 4'he;
    localparam logic [4:0] FULL_PT_MAX = 5'd16;
    // apb map
    localparam logic [11:0] ADR_CFG = 12'h000;
    localparam logic [11:0] ADR_STAT = 12'h004;
    localparam logic [11:0] ADR_PTR = 12'h008;
    localparam logic [11:0] ADR_CNT = 12'h00c;
    localparam int CFG_TRI_BIT = 0;
    localparam int CFG_FULL_BIT = 1;
    localparam logic [31:0] CFG_RESET = 32'h0000_0002;

    typedef enum logic [1:0] {
        LAYER_ETH = 2'd0,
        LAYER_CTRL = 2'd1,
        LAYER_MPLS = 2'd2,
        LAYER_DATA = 2'd3
    } layer_t;

    typedef enum logic [1:0] {
        SKIP_NONE = 2'd0,
        SKIP_L2 = 2'd1,
        SKIP_L3 = 2'd2,
        SKIP_RSV = 2'd3
    } skip_t;

    typedef enum logic [1:0] {
        FORCE_NONE = 2'd0,
        FORCE_XTR = 2'd1,
        FORCE_INJ = 2'd2,
        FORCE_LBK = 2'd3
    } force_t;

    // action word of one lookup; absent fields are driven zero
    typedef struct packed {
        logic valid;
        force_t force_pipeline_code;
        logic [2:0] short_pipeline_point;
        logic [4:0] full_pipeline_point;
        logic [3:0] next_lookup_key_select;
        logic [1:0] word_offset_step;
        logic [4:0] halfword_offset_step;
        skip_t layer_skip_select;
        layer_t layer_after_move;
        logic strip_leading_request;
    } action_t;

    // frame context from the parser
    typedef struct packed {
        layer_t layer;
        logic [7:0] ptr;
        logic [1:0] tag_cnt;
        logic [3:0] ip_version;
        logic [3:0] ip4_ihl;
    } frame_ctx_t;

    typedef struct packed {
        logic valid;
        logic [3:0] key_type;
        logic key_dst_swap;
        logic stop_lookups;
        logic [7:0] ptr;
        layer_t layer;
        logic pipe_valid;
        logic [4:0] pipe_point;
        force_t pipe_act;
        logic strip_valid;
        logic [7:0] strip_bytes;
    } result_t;
endpackage

// *** fp_layer_skip.sv ***
// layer skip length for the current frame context
// assumes parser supplies tag count, ip version and ipv4 header length
`timescale 1ns/1ps
module fp_layer_skip (
    // context
    input wire fp_pkg::frame_ctx_t ctx_i,
    input wire fp_pkg::skip_t sel_i,
    // result
    output logic [7:0] skip_bytes_o
);
    import fp_pkg::*;
    logic [7:0] l2_len;
    logic [7:0] ip_len;
    always_comb begin
        l2_len = MAC_BYTES + TYPE_BYTES + 8'(ctx_i.tag_cnt) * TAG_BYTES;
        ip_len = (ctx_i.ip_version == 4'h4) ? {2'b00, ctx_i.ip4_ihl, 2'b00}
                                            : IP6_BYTES;
        skip_bytes_o = 8'h00;
        case (sel_i)
            SKIP_L2: begin
                if (ctx_i.layer == LAYER_ETH) begin
                    skip_bytes_o = l2_len;
                end
            end
            SKIP_L3: begin
                if (ctx_i.layer == LAYER_ETH) begin
                    skip_bytes_o = 8'(l2_len + ip_len);
                end else if (ctx_i.layer == LAYER_CTRL &&
                        (ctx_i.ip_version == 4'h4 ||
                         ctx_i.ip_version == 4'h6)) begin
                    skip_bytes_o = ip_len;
                end
            end
            // reserved code moves nothing
            default: skip_bytes_o = 8'h00;
        endcase
    end
endmodule

// *** fp_key_select.sv ***
// next key selection decode
// assumes the per-lookup triple tag choice bit comes from configuration
`timescale 1ns/1ps
module fp_key_select (
    // request
    input wire logic [3:0] sel_i,
    input wire logic triple_tag_key_choice_i,
    // decode
    output logic [3:0] key_o,
    output logic dst_swap_o,
    output logic stop_o
);
    import fp_pkg::*;
    always_comb begin
        key_o = sel_i;
        dst_swap_o = (sel_i == KEY_NORMAL_DST);
        stop_o = (sel_i == KEY_DONE);
        // triple tag index key reported on code 14, the top code of the force key range
        if (sel_i == KEY_TRIPLE && triple_tag_key_choice_i) begin
            key_o = KEY_TRIPLE_IDX_OUT;
        end
    end
endmodule

// *** fp_action.sv ***
// action interpreter: pointer, layer, key, pipeline point, strip request
// assumes one action per cycle from lookup; apb master per amba protocol
`timescale 1ns/1ps
module fp_action (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // lookup action and frame context
    input wire fp_pkg::action_t ACTION_I,
    input wire fp_pkg::frame_ctx_t CTX_I,
    // to key generator and rewriter
    output fp_pkg::result_t RESULT_O
);
    import fp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] cfg_q;
    logic [7:0] last_ptr_q;
    layer_t last_layer_q;
    logic [15:0] act_cnt_q;
    logic sticky_clip_q;
    logic [31:0] rdata_d;
    logic apb_acc;
    logic addr_ok;

    assign apb_acc = PSEL_I && PENABLE_I;
    always_comb begin
        addr_ok = 1'b1;
        rdata_d = 32'h0000_0000;
        case (PADDR_I)
            ADR_CFG: rdata_d = {30'h0, cfg_q[1:0]};
            ADR_STAT: rdata_d = {29'h0, sticky_clip_q, last_layer_q};
            ADR_PTR: rdata_d = {24'h0, last_ptr_q};
            ADR_CNT: rdata_d = {16'h0, act_cnt_q};
            default: addr_ok = 1'b0;
        endcase
    end

    // zero wait state slave; unmapped address answers with an error
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !addr_ok;
            if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
                PRDATA_O <= rdata_d;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cfg_q <= CFG_RESET;
        end else if (apb_acc && PREADY_O && PWRITE_I &&
                PADDR_I == ADR_CFG) begin
            cfg_q <= {30'h0, PWDATA_I[1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pointer datapath
    action_t act;
    logic [7:0] skip_bytes;
    logic [8:0] ptr_after_skip;
    logic [8:0] ptr_new;
    logic moved;
    logic [3:0] key_sel;
    logic dst_swap;
    logic stop;
    layer_t layer_new;
    logic [7:0] strip_d;
    logic clip;

    // absent fields arrive zero, so an invalid action does nothing
    assign act = ACTION_I.valid ? ACTION_I : '0;

    fp_layer_skip u_skip (
        .ctx_i(CTX_I),
        .sel_i(act.layer_skip_select),
        .skip_bytes_o(skip_bytes)
    );

    fp_key_select u_key (
        .sel_i(act.next_lookup_key_select),
        .triple_tag_key_choice_i(cfg_q[CFG_TRI_BIT]),
        .key_o(key_sel),
        .dst_swap_o(dst_swap),
        .stop_o(stop)
    );

    always_comb begin
        // context pointer already passes skipped reserved labels
        ptr_after_skip = {1'b0, CTX_I.ptr} + {1'b0, skip_bytes};
        ptr_new = ptr_after_skip
                + {5'h0, act.word_offset_step, 2'b00}
                + {3'h0, act.halfword_offset_step, 1'b0};
        moved = (ptr_new[7:0] != CTX_I.ptr) || ptr_new[8];
        layer_new = CTX_I.layer;
        if (moved || (CTX_I.layer == LAYER_DATA &&
                act.next_lookup_key_select != KEY_DEFAULT)) begin
            layer_new = act.layer_after_move;
        end
        // strip length taken from the updated pointer
        clip = ptr_new[8] || (ptr_new[7:0] > MAX_STRIP);
        strip_d = clip ? MAX_STRIP : ptr_new[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // result register
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RESULT_O <= '0;
        end else begin
            RESULT_O.valid <= ACTION_I.valid;
            RESULT_O.key_type <= key_sel;
            RESULT_O.key_dst_swap <= dst_swap;
            RESULT_O.stop_lookups <= stop;
            RESULT_O.ptr <= ptr_new[7:0];
            RESULT_O.layer <= layer_new;
            RESULT_O.pipe_valid <= act.force_pipeline_code != FORCE_NONE;
            RESULT_O.pipe_act <= act.force_pipeline_code;
            if (cfg_q[CFG_FULL_BIT]) begin
                RESULT_O.pipe_point <= (act.full_pipeline_point > FULL_PT_MAX)
                    ? FULL_PT_MAX : act.full_pipeline_point;
            end else begin
                RESULT_O.pipe_point <= {2'b00, act.short_pipeline_point};
            end
            RESULT_O.strip_valid <= act.strip_leading_request;
            RESULT_O.strip_bytes <= act.strip_leading_request
                ? strip_d : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            last_ptr_q <= 8'h00;
            last_layer_q <= LAYER_ETH;
            act_cnt_q <= 16'h0000;
        end else if (ACTION_I.valid) begin
            last_ptr_q <= ptr_new[7:0];
            last_layer_q <= layer_new;
            act_cnt_q <= act_cnt_q + 16'h0001;
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sticky_clip_q <= 1'b0;
        end else if (act.strip_leading_request && clip) begin
            sticky_clip_q <= 1'b1;
        end else if (apb_acc && PREADY_O && PWRITE_I &&
                PADDR_I == ADR_STAT && PWDATA_I[2]) begin
            sticky_clip_q <= 1'b0;
        end
    end
endmodule

// *** fp_action_sva.sv ***
// checker for the action interpreter, watching its ports only
// assumes one core clock and an active low asynchronous reset
`timescale 1ns/1ps
module fp_action_sva (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // apb
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PREADY_O,
    // action side
    input wire fp_pkg::action_t ACTION_I,
    input wire fp_pkg::frame_ctx_t CTX_I,
    input wire fp_pkg::result_t RESULT_O
);
    import fp_pkg::*;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    ////////////////////////////////////////////////////////////////////////
    a_key_pass: assert property (ACTION_I.valid &&
        ACTION_I.next_lookup_key_select != KEY_TRIPLE |=> RESULT_O.valid &&
        RESULT_O.key_type == $past(ACTION_I.next_lookup_key_select))
        else $error("key select not passed on");
    a_stop_done: assert property (RESULT_O.valid |->
        RESULT_O.stop_lookups == (RESULT_O.key_type == KEY_DONE))
        else $error("stop flag wrong");
    a_dst_swap: assert property (RESULT_O.valid |->
        RESULT_O.key_dst_swap == (RESULT_O.key_type == KEY_NORMAL_DST))
        else $error("destination swap wrong");
    a_steady_ptr: assert property (ACTION_I.valid &&
        ACTION_I.layer_skip_select == SKIP_NONE &&
        ACTION_I.word_offset_step == 2'h0 &&
        ACTION_I.halfword_offset_step == 5'h00
        |=> RESULT_O.ptr == $past(CTX_I.ptr))
        else $error("pointer moved without request");
    a_word_step: assert property (ACTION_I.valid &&
        ACTION_I.layer_skip_select == SKIP_RSV &&
        ACTION_I.halfword_offset_step == 5'h00 |=> RESULT_O.ptr ==
        $past(CTX_I.ptr) + {$past(ACTION_I.word_offset_step), 2'b00})
        else $error("word step wrong");
    a_pipe_force: assert property (ACTION_I.valid |=>
        RESULT_O.pipe_valid == ($past(ACTION_I.force_pipeline_code) != 0))
        else $error("pipeline force flag wrong");
    a_pipe_range: assert property (RESULT_O.pipe_valid |->
        RESULT_O.pipe_point <= FULL_PT_MAX)
        else $error("pipeline point out of range");
    a_strip_max: assert property (RESULT_O.strip_valid |->
        RESULT_O.strip_bytes == (RESULT_O.ptr > MAX_STRIP ?
        MAX_STRIP : RESULT_O.ptr))
        else $error("strip length wrong");
    a_no_strip: assert property (ACTION_I.valid &&
        !ACTION_I.strip_leading_request |=> !RESULT_O.strip_valid)
        else $error("strip without request");
    a_apb_ready: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("apb answer late");
    c_strip: cover property (RESULT_O.strip_valid && RESULT_O.ptr > MAX_STRIP);
    c_stop: cover property (RESULT_O.valid && RESULT_O.stop_lookups);
    c_force: cover property (RESULT_O.pipe_valid);
endmodule
bind fp_action fp_action_sva chk (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O),
    .ACTION_I(ACTION_I), .CTX_I(CTX_I), .RESULT_O(RESULT_O));

// *** fp_rewriter_model.sv ***
// rewriter and key generator stand-in at the result side
// assumes results arrive as one-cycle pulses in the core clock
`timescale 1ns/1ps
module fp_rewriter_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // result
    input wire fp_pkg::result_t res_i,
    // observed
    output logic [7:0] stripped_o,
    output logic stopped_o
);
    import fp_pkg::*;
    // only the last strip is kept; forwarding data itself is not modelled
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stripped_o <= 8'h00;
            stopped_o <= 1'b0;
        end else if (res_i.valid) begin
            if (res_i.strip_valid) stripped_o <= res_i.strip_bytes;
            stopped_o <= res_i.stop_lookups;
        end
    end
endmodule

// *** fp_action_bench.sv ***
// self-checking bench: random actions, apb register checks
// assumes the rewriter model sits on the result port
`timescale 1ns/1ps
module fp_action_bench;
    import fp_pkg::*;
    logic clk, nrst, psel, pen, pwr, prdy, perr, stopped;
    logic [11:0] padr;
    logic [31:0] pwd, prd, q, cf;
    logic [7:0] stripped, lastptr;
    logic e, clipped;
    layer_t lastlay;
    action_t act, a;
    frame_ctx_t ctx, c;
    result_t res, ex, ex_old, ex_old2;
    int fail_count, n_tests, nv;
    fp_action uut (.CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
        .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .ACTION_I(act),
        .CTX_I(ctx), .RESULT_O(res));
    fp_rewriter_model rw (.clk_i(clk), .nrst_i(nrst), .res_i(res),
        .stripped_o(stripped), .stopped_o(stopped));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [63:0] got, input logic [63:0] want);
        n_tests++;
        if (got !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pwr <= w; padr <= ad; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 20);
        q = prd; e = perr;
        psel <= 1'b0; pen <= 1'b0;
        if (prdy !== 1'b1) begin
            fail_count++;
            final_report();
        end
    endtask
    // expected result worked out from the action fields and frame context
    function automatic result_t calc(action_t a, frame_ctx_t c);
        result_t r;
        logic [7:0] s, ip;
        r = '0;
        r.valid = a.valid;
        ip = c.ip_version == 4'h4 ? {2'b00, c.ip4_ihl, 2'b00} :
            (c.ip_version == 4'h6 ? IP6_BYTES : 8'h00);
        s = 8'h00;
        if (c.layer == LAYER_ETH &&
                a.layer_skip_select inside {SKIP_L2, SKIP_L3})
            s = MAC_BYTES + TYPE_BYTES + TAG_BYTES * c.tag_cnt;
        if (a.layer_skip_select == SKIP_L3 &&
                c.layer inside {LAYER_ETH, LAYER_CTRL})
            s = s + ip;
        r.ptr = c.ptr + s + {a.word_offset_step, 2'b00} +
            {a.halfword_offset_step, 1'b0};
        r.layer = (r.ptr != c.ptr || (c.layer == LAYER_DATA &&
            a.next_lookup_key_select != 4'h0)) ? a.layer_after_move : c.layer;
        r.key_type = (a.next_lookup_key_select == KEY_TRIPLE && cf[CFG_TRI_BIT])
            ? KEY_TRIPLE_IDX_OUT : a.next_lookup_key_select;
        r.key_dst_swap = a.next_lookup_key_select == KEY_NORMAL_DST;
        r.stop_lookups = a.next_lookup_key_select == KEY_DONE;
        r.pipe_valid = a.force_pipeline_code != FORCE_NONE;
        r.pipe_act = a.force_pipeline_code;
        r.pipe_point = !cf[CFG_FULL_BIT] ? {2'b00, a.short_pipeline_point} :
            (a.full_pipeline_point > FULL_PT_MAX ? FULL_PT_MAX :
            a.full_pipeline_point);
        r.strip_valid = a.strip_leading_request;
        r.strip_bytes = !r.strip_valid ? 8'h00 :
            (r.ptr > MAX_STRIP ? MAX_STRIP : r.ptr);
        if (!r.pipe_valid) r.pipe_point = 5'h00;
        return r;
    endfunction
    task automatic run(input int cnt);
        result_t g;
        ex_old = '0;
        ex_old2 = '0;
        for (int i = 0; i <= cnt; i++) begin
            a = action_t'(27'($urandom));
            c = frame_ctx_t'(20'($urandom));
            a.valid = i < cnt && ($urandom % 8) != 0;
            c.ptr = 8'($urandom % 41);
            if (c.layer == LAYER_ETH)
                c.ip_version = ($urandom % 2) ? 4'h4 : 4'h6;
            if (c.ip_version == 4'h4) c.ip4_ihl = 4'(5 + $urandom % 11);
            if (i % 8 == 0) begin
                a.layer_skip_select = SKIP_NONE;
                a.word_offset_step = 2'h0;
                a.halfword_offset_step = 5'h00;
            end
            // corner: pointer well past the strip limit
            if (i % 16 == 3) begin
                a.strip_leading_request = 1'b1;
                a.halfword_offset_step = 5'h1f;
            end
            @(posedge clk);
            act <= a;
            ctx <= c;
            ex = calc(a, c);
            #1;
            // point is a don't care while no forcing is asked for
            g = res;
            if (!g.pipe_valid) g.pipe_point = 5'h00;
            if (i > 0) cmp(g.valid, ex_old.valid);
            if (i > 0 && ex_old.valid) begin
                cmp(g, ex_old);
                cmp(g.layer, ex_old.layer);
                lastptr = ex_old.ptr;
                lastlay = ex_old.layer;
                nv++;
                if (ex_old.strip_valid && ex_old.ptr > MAX_STRIP)
                    clipped = 1'b1;
            end
            // the far side model lags the result port by one more cycle
            if (ex_old2.valid && ex_old2.strip_valid)
                cmp(stripped, ex_old2.strip_bytes);
            if (ex_old2.valid) cmp(stopped, ex_old2.stop_lookups);
            ex_old2 = ex_old;
            ex_old = ex;
        end
    endtask
    initial begin
        nrst = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
        padr = 12'h000; pwd = 32'h0; act = '0; ctx = '0;
        fail_count = 0; n_tests = 0; cf = CFG_RESET;
        nv = 0; clipped = 1'b0; lastlay = LAYER_ETH;
        void'($urandom(32'he1ab0823));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, ADR_CFG, 32'h0);
        cmp(q, CFG_RESET);
        run(300);
        cf = 32'h0000_0001;
        apb(1'b1, ADR_CFG, cf);
        apb(1'b0, ADR_CFG, 32'h0);
        cmp(q, cf);
        run(300);
        apb(1'b0, ADR_PTR, 32'h0);
        cmp(q, {24'h0, lastptr});
        apb(1'b0, ADR_STAT, 32'h0);
        cmp(q, {29'h0, clipped, lastlay});
        apb(1'b1, ADR_STAT, 32'h0000_0004);
        apb(1'b0, ADR_STAT, 32'h0);
        cmp(q, {30'h0, lastlay});
        apb(1'b0, ADR_CNT, 32'h0);
        cmp(q, nv);
        apb(1'b0, 12'h0f0, 32'h0);
        cmp({q[30:0], e}, 32'h1);
        final_report();
    end
endmodule
